// ===== hpw_pkg.sv
package hpw_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_MEM_FMT = 8'h2a;
  localparam logic [7:0] REG_GAMMA_DATA = 8'h32;
  localparam logic [7:0] REG_EFFECTS = 8'h36;
  localparam logic [7:0] REG_WIN_FIRST = 8'h38;
  localparam logic [7:0] REG_WIN_LAST = 8'h46;
  localparam logic [7:0] REG_PIX_LOW = 8'h48;
  localparam logic [7:0] REG_PIX_HIGH = 8'h49;
  localparam logic [7:0] REG_RDADDR0 = 8'h4a;
  localparam logic [7:0] REG_RDADDR1 = 8'h4c;
  localparam logic [7:0] REG_RDADDR2 = 8'h4e;
  localparam logic [7:0] REG_MSB_EXT = 8'h50;
  localparam logic [7:0] REG_VPERIOD = 8'h58;

  // ----------------------------------------------------------------
  // fields, steps and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_STEP = 8'h02;
  localparam logic [7:0] EFFECTS_RESET = 8'h00;
  localparam logic [7:0] MEM_FMT_RESET = 8'h00;
  localparam logic [1:0] FMT_18BPP = 2'b00;
  localparam logic [1:0] FMT_16BPP = 2'b01;
  localparam int DB_MSB = 7;
  localparam int DB_LSB = 6;
  localparam logic [1:0] DB_VIDEO = 2'b11;
  localparam int DB_ON_BIT = 6;
  localparam int VPERIOD_BIT = 7;
  localparam logic [19:0] HALF_BASE = 20'h60000;

  // rotation select, low bits of the effects register
  typedef enum logic [1:0] {
    HPW_ROT_0 = 2'b00,
    HPW_ROT_90 = 2'b01,
    HPW_ROT_180 = 2'b11,
    HPW_ROT_270 = 2'b10
  } hpw_rot_t;

endpackage : hpw_pkg

// ===== hpw_host_port.sv
`timescale 1ns/1ps
module hpw_host_port
  import hpw_pkg::*;
#(
  parameter logic [9:0] PANEL_W = 10'd352,
  parameter logic [9:0] PANEL_H = 10'd416
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic dc_i,
  input wire logic we_b_i,
  input wire logic rd_b_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  input wire logic bus_width_strap_i,
  input wire logic vnd_i,
  output logic tearing_sync_output_o,
  output logic mem_wr_o,
  output logic [19:0] mem_addr_o,
  output logic [1:0] mem_be_o,
  output logic [15:0] mem_wdata_o,
  output logic mem_msb_wr_o,
  output logic [19:0] mem_msb_addr_o,
  output logic [1:0] mem_msb_data_o,
  output logic mem_rd_o,
  input wire logic [15:0] mem_rdata_i,
  output logic gamma_wr_o,
  output logic [7:0] gamma_data_o,
  output logic video_from_lower_o,
  output logic [9:0] video_x_first_o,
  output logic [9:0] video_y_first_o,
  output logic [9:0] video_x_last_o,
  output logic [9:0] video_y_last_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] fx;
    logic [7:0] fmt;
    logic [7:0] msbx;
    logic [7:0][7:0] win;
    logic [23:0] rdaddr;
    logic [9:0] cx;
    logic [9:0] cy;
    logic phase;
    logic we_q;
    logic rd_q;
    logic vnd_q;
    logic strap;
    logic strap_done;
    logic [15:0] dout;
    logic oe;
    logic rd_pend;
    logic mem_wr;
    logic [19:0] mem_addr;
    logic [1:0] mem_be;
    logic [15:0] mem_wdata;
    logic msb_wr;
    logic [19:0] msb_addr;
    logic [1:0] msb_data;
    logic mem_rd;
    logic gamma_wr;
    logic [7:0] gamma_data;
    logic frame_done;
    logic writing;
    logic wr_lower;
    logic vid_lower;
    logic [3:0][9:0] dbw;
  } hpw_state_t;

  hpw_state_t s_reg;
  hpw_state_t s_next;

  // ----------------------------------------------------------------
  // decoded strobes and window geometry
  // ----------------------------------------------------------------
  logic wr_evt;
  logic rd_evt;
  logic on_port;
  logic db_on;
  logic video_mode;
  logic [9:0] xs;
  logic [9:0] ys;
  logic [9:0] xe;
  logic [9:0] ye;
  logic [9:0] dx;
  logic [9:0] dy;
  logic [18:0] pix;
  logic [19:0] wbase;
  logic [7:0] rd_val;
  logic frame_end;

  // falling strobe edges, only while selected
  // chip select gate
  assign wr_evt = !cs_b_i && !we_b_i && s_reg.we_q;
  assign rd_evt = !cs_b_i && !rd_b_i && s_reg.rd_q;
  assign on_port = (s_reg.ptr == REG_PIX_LOW) || (s_reg.ptr == REG_PIX_HIGH);
  assign db_on = s_reg.fx[DB_ON_BIT];
  assign video_mode = (s_reg.fx[DB_MSB:DB_LSB] == DB_VIDEO);
  assign xs = {s_reg.win[1][1:0], s_reg.win[0]};
  assign ys = {s_reg.win[3][1:0], s_reg.win[2]};
  assign xe = {s_reg.win[5][1:0], s_reg.win[4]};
  assign ye = {s_reg.win[7][1:0], s_reg.win[6]};

  // rotation folds into the address, so the host never recomputes offsets
  // hardware address derivation
  always_comb begin
    case (hpw_rot_t'(s_reg.fx[1:0]))
      HPW_ROT_90: begin
        dx = s_reg.cy;
        dy = 10'(PANEL_H - 10'd1 - s_reg.cx);
      end
      HPW_ROT_180: begin
        dx = 10'(PANEL_W - 10'd1 - s_reg.cx);
        dy = 10'(PANEL_H - 10'd1 - s_reg.cy);
      end
      HPW_ROT_270: begin
        dx = 10'(PANEL_W - 10'd1 - s_reg.cy);
        dy = s_reg.cx;
      end
      default: begin
        dx = s_reg.cx;
        dy = s_reg.cy;
      end
    endcase
  end

  // widened before the product, a ten-bit multiply would wrap past row two
  assign pix = 19'(19'(dy) * 19'(PANEL_W) + 19'(dx));
  // video lands over any static overlay in its half
  // static to upper, video to the current write half
  assign wbase = (video_mode && s_reg.wr_lower) ? HALF_BASE : 20'h00000;

  // register read mux, eight bits wide
  always_comb begin
    rd_val = 8'h00;
    if (s_reg.ptr >= REG_WIN_FIRST && s_reg.ptr <= REG_WIN_LAST) begin
      rd_val = s_reg.win[3'(8'(s_reg.ptr - REG_WIN_FIRST) >> 1)];
    end else begin
      case (s_reg.ptr)
        REG_EFFECTS: rd_val = s_reg.fx;
        REG_MEM_FMT: rd_val = s_reg.fmt;
        REG_RDADDR0: rd_val = s_reg.rdaddr[7:0];
        REG_RDADDR1: rd_val = s_reg.rdaddr[15:8];
        REG_RDADDR2: rd_val = s_reg.rdaddr[23:16];
        REG_MSB_EXT: rd_val = s_reg.msbx;
        REG_VPERIOD: rd_val = {s_reg.vnd_q, 7'h00};
        default: rd_val = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.mem_wr = 1'b0;
    s_next.mem_rd = 1'b0;
    s_next.msb_wr = 1'b0;
    s_next.gamma_wr = 1'b0;
    frame_end = 1'b0;
    s_next.we_q = we_b_i;
    s_next.rd_q = rd_b_i;
    s_next.vnd_q = vnd_i;
    s_next.oe = !cs_b_i && !rd_b_i && dc_i;
    // strap caught once, on the first edge after reset release
    if (!s_reg.strap_done) begin
      s_next.strap = bus_width_strap_i;
      s_next.strap_done = 1'b1;
    end
    // memory answer lands one cycle after the read request
    if (s_reg.rd_pend) begin
      s_next.dout = mem_rdata_i;
      s_next.rd_pend = 1'b0;
    end
    // address cycle when the select pin is low
    if (wr_evt && !dc_i) begin
      s_next.ptr = data_i[7:0];
      if (data_i[7:0] == REG_PIX_LOW || data_i[7:0] == REG_PIX_HIGH) begin
        s_next.cx = xs;
        s_next.cy = ys;
        s_next.phase = 1'b0;
      end
    end else if (wr_evt && on_port) begin
      // newer window pixels overwrite older ones
      s_next.mem_wr = 1'b1;
      // byte or word lane per strap
      s_next.mem_addr = 20'(wbase + {pix, 1'b0} + {19'h0, s_reg.phase & !s_reg.strap});
      s_next.mem_be = s_reg.strap ? 2'b11 : (s_reg.phase ? 2'b10 : 2'b01);
      s_next.mem_wdata = s_reg.strap ? data_i : {data_i[7:0], data_i[7:0]};
      if (s_reg.strap || s_reg.phase) begin
        s_next.phase = 1'b0;
        // msb plane kept apart from the low word
        s_next.msb_wr = (s_reg.fmt[1:0] == FMT_18BPP);
        s_next.msb_addr = {video_mode && s_reg.wr_lower, pix};
        s_next.msb_data = s_reg.msbx[1:0];
        // memory address advances across the window
        if (s_reg.cx == xe) begin
          s_next.cx = xs;
          s_next.cy = (s_reg.cy == ye) ? ys : 10'(s_reg.cy + 10'd1);
        end else begin
          s_next.cx = 10'(s_reg.cx + 10'd1);
        end
        if (video_mode) begin
          // only the streaming window is tracked
          if (!s_reg.writing) begin
            s_next.dbw = {ye, xe, ys, xs};
          end
          s_next.writing = 1'b1;
          if (s_reg.cx == xe && s_reg.cy == ye) begin
            s_next.writing = 1'b0;
            s_next.frame_done = 1'b1;
            frame_end = 1'b1;
          end
        end
      end else begin
        s_next.phase = 1'b1;
      end
    end else if (wr_evt && s_reg.ptr == REG_GAMMA_DATA) begin
      // gamma data keeps the pointer for bursts
      s_next.gamma_wr = 1'b1;
      s_next.gamma_data = data_i[7:0];
    end else if (wr_evt) begin
      if (s_reg.ptr >= REG_WIN_FIRST && s_reg.ptr <= REG_WIN_LAST) begin
        s_next.win[3'(8'(s_reg.ptr - REG_WIN_FIRST) >> 1)] = data_i[7:0];
      end
      case (s_reg.ptr)
        REG_EFFECTS: s_next.fx = data_i[7:0];
        REG_MEM_FMT: s_next.fmt = data_i[7:0];
        REG_RDADDR0: s_next.rdaddr[7:0] = data_i[7:0];
        REG_RDADDR1: s_next.rdaddr[15:8] = data_i[7:0];
        REG_RDADDR2: s_next.rdaddr[23:16] = data_i[7:0];
        REG_MSB_EXT: s_next.msbx = data_i[7:0];
        default: s_next.ptr = s_reg.ptr;
      endcase
      s_next.ptr = 8'(s_reg.ptr + PTR_STEP);
      // eighth step lands on the pixel port
      if (8'(s_reg.ptr + PTR_STEP) == REG_PIX_LOW) begin
        s_next.cx = xs;
        s_next.cy = ys;
        s_next.phase = 1'b0;
      end
    end else if (rd_evt && dc_i && on_port) begin
      if (s_reg.fmt[1:0] == FMT_16BPP) begin
        s_next.mem_rd = 1'b1;
        s_next.rd_pend = 1'b1;
        // lsb dropped on a wide bus
        s_next.mem_addr = s_reg.strap ? {s_reg.rdaddr[19:1], 1'b0} : s_reg.rdaddr[19:0];
        s_next.rdaddr = 24'(s_reg.rdaddr + (s_reg.strap ? 24'h000002 : 24'h000001));
      end else begin
        s_next.dout = 16'h0000;
      end
    end else if (rd_evt && dc_i) begin
      s_next.dout = {8'h00, rd_val};
      if (s_reg.ptr != REG_GAMMA_DATA) begin
        s_next.ptr = 8'(s_reg.ptr + PTR_STEP);
      end
    end
    if (!db_on) begin
      // display pointer back to upper at once
      s_next.vid_lower = 1'b0;
      s_next.wr_lower = 1'b1;
      s_next.frame_done = 1'b0;
      s_next.writing = 1'b0;
    end else if (vnd_i && !s_reg.vnd_q && s_reg.frame_done && !s_reg.writing) begin
      // video source follows the completed half
      s_next.vid_lower = s_reg.wr_lower;
      s_next.wr_lower = !s_reg.wr_lower;
      // a frame finishing this same cycle keeps its flag
      s_next.frame_done = frame_end;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
      s_reg.fx <= EFFECTS_RESET;
      s_reg.fmt <= MEM_FMT_RESET;
      s_reg.we_q <= 1'b1;
      s_reg.rd_q <= 1'b1;
      s_reg.wr_lower <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state
  assign data_o = s_reg.dout;
  assign data_oe_o = s_reg.oe;
  assign tearing_sync_output_o = s_reg.vnd_q;
  assign mem_wr_o = s_reg.mem_wr;
  assign mem_addr_o = s_reg.mem_addr;
  assign mem_be_o = s_reg.mem_be;
  assign mem_wdata_o = s_reg.mem_wdata;
  assign mem_msb_wr_o = s_reg.msb_wr;
  assign mem_msb_addr_o = s_reg.msb_addr;
  assign mem_msb_data_o = s_reg.msb_data;
  assign mem_rd_o = s_reg.mem_rd;
  assign gamma_wr_o = s_reg.gamma_wr;
  assign gamma_data_o = s_reg.gamma_data;
  assign video_from_lower_o = s_reg.vid_lower;
  assign video_x_first_o = s_reg.dbw[0];
  assign video_y_first_o = s_reg.dbw[1];
  assign video_x_last_o = s_reg.dbw[2];
  assign video_y_last_o = s_reg.dbw[3];

endmodule : hpw_host_port

// ===== hpw_host_port_properties.sv
`timescale 1ns/1ps
module hpw_host_port_properties
  import hpw_pkg::*;
#(
  parameter logic [9:0] PANEL_W = 10'd352,
  parameter logic [9:0] PANEL_H = 10'd416
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic dc_i,
  input wire logic we_b_i,
  input wire logic rd_b_i,
  input wire logic bus_width_strap_i,
  input wire logic vnd_i,
  input wire logic tearing_sync_output_o,
  input wire logic data_oe_o,
  input wire logic mem_wr_o,
  input wire logic [1:0] mem_be_o,
  input wire logic mem_rd_o,
  input wire logic gamma_wr_o,
  input wire logic video_from_lower_o
);
  // -------------------------------------------
  // host port relations
  // -------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_sync_follows_vnd: assert property ($rose(vnd_i) |=> tearing_sync_output_o)
    else $error("tearing sync missed a rising vnd");
  a_cs_blocks_all: assert property (cs_b_i |=> !(mem_wr_o || mem_rd_o || gamma_wr_o))
    else $error("access taken while deselected");
  a_wr_from_strobe: assert property (mem_wr_o |-> $past(!cs_b_i && !we_b_i && dc_i))
    else $error("memory write without a data write strobe");
  a_rd_from_strobe: assert property (mem_rd_o |-> $past(!cs_b_i && !rd_b_i && dc_i))
    else $error("memory read without a data read strobe");
  a_wr_one_pulse: assert property (mem_wr_o |=> !mem_wr_o)
    else $error("memory write longer than one cycle");
  a_oe_on_read: assert property (data_oe_o == $past(!cs_b_i && !rd_b_i && dc_i))
    else $error("bus driver enable wrong");
  a_wide_full_lanes: assert property (bus_width_strap_i && mem_wr_o |-> mem_be_o == 2'b11)
    else $error("wide port did not write both lanes");
  a_swap_after_vnd: assert property ($rose(video_from_lower_o) |-> $past(vnd_i) || $past(vnd_i, 2))
    else $error("buffer swap outside vertical non-display");

  c_mem_write: cover property (mem_wr_o);
  c_mem_read: cover property (mem_rd_o);
  c_swap: cover property ($rose(video_from_lower_o));
endmodule : hpw_host_port_properties

bind hpw_host_port hpw_host_port_properties #(.PANEL_W(PANEL_W), .PANEL_H(PANEL_H)) hpw_host_port_properties_inst (
  .clk_i, .rst_b_i, .cs_b_i, .dc_i, .we_b_i, .rd_b_i, .bus_width_strap_i, .vnd_i,
  .tearing_sync_output_o, .data_oe_o, .mem_wr_o, .mem_be_o, .mem_rd_o, .gamma_wr_o, .video_from_lower_o
);

// ===== hpw_host_model.sv
`timescale 1ns/1ps
module hpw_host_model (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output logic cs_b_o,
  output logic dc_o,
  output logic we_b_o,
  output logic rd_b_o,
  output logic [15:0] wdata_o
);
  // idle bus, strobes high so the first fall is seen
  initial begin
    cs_b_o = 1'b1;
    dc_o = 1'b0;
    we_b_o = 1'b1;
    rd_b_o = 1'b1;
    wdata_o = 16'h0000;
  end

  task automatic cyc(input logic dc, input logic wr, input logic [15:0] d, input logic cs, output logic [15:0] q);
    @(posedge clk_i);
    cs_b_o <= cs;
    dc_o <= dc;
    wdata_o <= d;
    if (wr) we_b_o <= 1'b0;
    else rd_b_o <= 1'b0;
    // held long enough for a memory read answer
    repeat (3) @(posedge clk_i);
    #1 q = rdata_i;
    @(posedge clk_i);
    we_b_o <= 1'b1;
    rd_b_o <= 1'b1;
    cs_b_o <= 1'b1;
    // released data never shows the last value
    wdata_o <= ~d;
  endtask : cyc
endmodule : hpw_host_model

// ===== hpw_host_port_test.sv
`timescale 1ns/1ps
module hpw_host_port_test;
  import hpw_pkg::*;
  localparam int W = 352;
  logic clk_i, rst_b_i, strap, vnd, cs_b, dc, we_b, rd_b, oe, tsync, mem_wr, mem_rd, lower;
  logic [15:0] hdata, dout, mem_rdata, q;
  logic [19:0] mem_addr, wr_addr, rd_addr;
  logic msb_wr, gamma_wr;
  logic [1:0] mem_be, wr_be, msb_data, msb_dlast;
  logic [7:0] gamma_data, gamma_last;
  logic [9:0] vxf, vyf, vxl, vyl;
  logic [15:0] mem_wdata, wr_data;
  logic [19:0] msb_addr, msb_last;
  int gamma_count = 0;
  int failures = 0;
  int check_count = 0;
  int wr_count = 0;

  hpw_host_model hpw_host_model_inst (.clk_i(clk_i), .rdata_i(dout), .cs_b_o(cs_b), .dc_o(dc),
    .we_b_o(we_b), .rd_b_o(rd_b), .wdata_o(hdata));
  // panel size is fixed here, before any window data
  hpw_host_port #(.PANEL_W(10'(W)), .PANEL_H(10'd416)) hpw_host_port_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .cs_b_i(cs_b), .dc_i(dc), .we_b_i(we_b), .rd_b_i(rd_b), .data_i(hdata), .data_o(dout), .data_oe_o(oe),
    .bus_width_strap_i(strap), .vnd_i(vnd), .tearing_sync_output_o(tsync), .mem_wr_o(mem_wr),
    .mem_addr_o(mem_addr), .mem_be_o(mem_be), .mem_wdata_o(mem_wdata), .mem_msb_wr_o(msb_wr),
    .mem_msb_addr_o(msb_addr), .mem_msb_data_o(msb_data), .mem_rd_o(mem_rd), .mem_rdata_i(mem_rdata),
    .gamma_wr_o(gamma_wr), .gamma_data_o(gamma_data), .video_from_lower_o(lower), .video_x_first_o(vxf),
    .video_y_first_o(vyf), .video_x_last_o(vxl), .video_y_last_o(vyl));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // record memory strobes and their addresses
  always @(posedge clk_i) begin
    if (mem_wr === 1'b1) begin
      wr_count <= wr_count + 1;
      wr_addr <= mem_addr;
      wr_be <= mem_be;
      wr_data <= mem_wdata;
    end
    if (mem_rd === 1'b1) rd_addr <= mem_addr;
    if (msb_wr === 1'b1) begin
      msb_last <= msb_addr;
      msb_dlast <= msb_data;
    end
    if (gamma_wr === 1'b1) begin
      gamma_count <= gamma_count + 1;
      gamma_last <= gamma_data;
    end
  end

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic aw(input logic [7:0] a);
    hpw_host_model_inst.cyc(1'b0, 1'b1, {8'h00, a}, 1'b0, q);
  endtask : aw
  task automatic dw(input logic [15:0] d);
    hpw_host_model_inst.cyc(1'b1, 1'b1, d, 1'b0, q);
  endtask : dw
  task automatic dr();
    hpw_host_model_inst.cyc(1'b1, 1'b0, 16'h0000, 1'b0, q);
  endtask : dr
  // address cycle, then eight coordinate bytes
  task automatic win(input logic [7:0] xs, input logic [7:0] ys, input logic [7:0] xe, input logic [7:0] ye);
    logic [7:0] v[8];
    v = '{xs, 8'h00, ys, 8'h00, xe, 8'h00, ye, 8'h00};
    aw(REG_WIN_FIRST);
    for (int i = 0; i < 8; i++) dw({8'h00, v[i]});
  endtask : win
  // host lets the swap happen before the next frame
  task automatic vpulse();
    vnd <= 1'b1;
    repeat (4) @(posedge clk_i);
    vnd <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : vpulse

  task automatic s_regs();
    int n;
    aw(REG_EFFECTS);
    dr();
    chk({12'h000, q[7:0]}, {12'h000, EFFECTS_RESET});
    aw(REG_WIN_FIRST);
    dw(16'h005a);
    dw(16'h00a5);
    aw(REG_WIN_FIRST);
    dr();
    chk({12'h000, q[7:0]}, 20'h0005a);
    dr();
    chk({12'h000, q[7:0]}, 20'h000a5);
    // gamma data holds the pointer, so both writes reach the table
    n = gamma_count;
    aw(REG_GAMMA_DATA);
    dw(16'h0011);
    dw(16'h0022);
    chk(20'(gamma_count - n), 20'h00002);
    chk({12'h000, gamma_last}, 20'h00022);
  endtask : s_regs

  task automatic s_window();
    int n;
    aw(REG_MSB_EXT);
    dw(16'h0002);
    win(8'h02, 8'h01, 8'h03, 8'h01);
    for (int i = 0; i < 3; i++) begin
      n = wr_count;
      dw(16'h1230 + 16'(i));
      chk(20'(wr_count - n), 20'h00001);
      chk(wr_addr, 20'(2 * (W + 2 + i % 2)));
      chk({4'h0, wr_data}, {4'h0, 16'h1230 + 16'(i)});
      chk({18'h00000, wr_be}, 20'h00003);
      chk(msb_last, 20'(W + 2 + i % 2));
    end
    chk({18'h00000, msb_dlast}, 20'h00002);
    // deselected write must leave the window counters alone
    n = wr_count;
    hpw_host_model_inst.cyc(1'b1, 1'b1, 16'h0bad, 1'b1, q);
    chk(20'(wr_count - n), 20'h00000);
    dw(16'h1233);
    chk(wr_addr, 20'(2 * (W + 3)));
    aw(REG_PIX_LOW);
    dw(16'h1234);
    chk(wr_addr, 20'(2 * (W + 2)));
  endtask : s_window

  task automatic s_dbuf();
    aw(REG_EFFECTS);
    dw(16'h00c0);
    win(8'h01, 8'h01, 8'h01, 8'h01);
    dw(16'h0001);
    chk(wr_addr, 20'(HALF_BASE + 2 * (W + 1)));
    chk({10'h000, vxf}, 20'h00001);
    chk({10'h000, vyf}, 20'h00001);
    vpulse();
    chk({19'h00000, lower}, 20'h00001);
    dw(16'h0002);
    chk(wr_addr, 20'(2 * (W + 1)));
    vpulse();
    chk({19'h00000, lower}, 20'h00000);
    vpulse();
    chk({19'h00000, lower}, 20'h00000);
    dw(16'h0003);
    vpulse();
    chk({19'h00000, lower}, 20'h00001);
    // static insert after the last video pixel
    aw(REG_EFFECTS);
    dw(16'h0040);
    win(8'h05, 8'h00, 8'h05, 8'h00);
    dw(16'h0004);
    chk(wr_addr, 20'h0000a);
    chk({10'h000, vxl}, 20'h00001);
    chk({10'h000, vyl}, 20'h00001);
    aw(REG_EFFECTS);
    dw(16'h0000);
    chk({19'h00000, lower}, 20'h00000);
  endtask : s_dbuf

  task automatic s_read();
    aw(REG_MEM_FMT);
    dw({14'h0000, FMT_16BPP});
    aw(REG_RDADDR0);
    dw(16'h0035);
    dw(16'h0012);
    dw(16'h0000);
    mem_rdata <= 16'hbeef;
    aw(REG_PIX_LOW);
    dr();
    chk(rd_addr, 20'h01234);
    chk({4'h0, q}, 20'h0beef);
    mem_rdata <= 16'h5a5a;
    dr();
    chk(rd_addr, 20'h01236);
    chk({4'h0, q}, 20'h05a5a);
  endtask : s_read

  // strap is caught after reset only, so the narrow port needs a fresh reset
  task automatic s_narrow();
    int n;
    strap <= 1'b0;
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    win(8'h01, 8'h00, 8'h01, 8'h00);
    n = wr_count;
    dw(16'h00a1);
    chk(wr_addr, 20'h00002);
    chk({18'h00000, wr_be}, 20'h00001);
    chk({4'h0, wr_data}, 20'h0a1a1);
    dw(16'h00b2);
    chk(wr_addr, 20'h00003);
    chk({18'h00000, wr_be}, 20'h00002);
    chk({4'h0, wr_data}, 20'h0b2b2);
    chk(20'(wr_count - n), 20'h00002);
  endtask : s_narrow

  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    test_done();
  end

  initial begin
    rst_b_i = 1'b0;
    strap = 1'b1;
    vnd = 1'b0;
    mem_rdata = 16'h0000;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    s_regs();
    s_window();
    s_dbuf();
    s_read();
    s_narrow();
    test_done();
  end
endmodule : hpw_host_port_test
